// [inc/hcpp_consts.vh]
// Constants for the hex command protocol parser
// Behaviour
// - Get or read with a wrong checksum gets no reply at all.
// - Upper-case letter: standard form, 16-bit address, 8-bit size.
// - Lower-case letter: extended form, 32-bit address, 16-bit size (8-bit size for table unload).
// - Extended put and protected write move at most 1024 bytes.
// - Standard address is four hex characters, most significant first.
// - Extended address is eight hex characters, most significant first.
// - Standard size is two hex characters; zero means 256 bytes.
// - Extended size is four hex characters; zero means 65536 bytes.
// - Checksum: 16-bit byte sum excluding letter and checksum, four hex.
// - Protected commands carry serial number password, low byte first.
// - Error code goes out as two hex characters, zero is success.
// - Test and initialise carry an 8-bit parameter after the password.
// - Every data byte travels as two hex characters.
// - Get: letter, address, size; reply data bytes, code if extended, then checksum.
// - Put: letter, address, size, data; extended replies code, checksum.
// - Protected write: letter, password, address, size, data bytes.
// - Protected read: letter, password, address, size; reply data, code if extended, sum.
// - Partial table unload takes two-hex size; reply table data, sum.
`ifndef HCPP_CONSTS_VH
`define HCPP_CONSTS_VH
`define HCPP_CH_CR 8'h0d
`define HCPP_CMD_GET 8'h47
`define HCPP_CMD_PUT 8'h50
`define HCPP_CMD_WRP 8'h57
`define HCPP_CMD_RDP 8'h52
`define HCPP_CMD_TST 8'h54
`define HCPP_CMD_INI 8'h49
`define HCPP_CMD_TBL 8'h53
`define HCPP_CMD_NUM 8'h4e
`define HCPP_CMD_OFF 8'h4b
`define HCPP_CASE_BIT 5
`define HCPP_NIBS_PASS 4'h4
`define HCPP_NIBS_ADDR_STD 4'h4
`define HCPP_NIBS_ADDR_EXT 4'h8
`define HCPP_NIBS_SIZE_STD 4'h2
`define HCPP_NIBS_SIZE_EXT 4'h4
`define HCPP_NIBS_PARAM 4'h2
`define HCPP_NIBS_CKS 4'h4
`define HCPP_SIZE_ZERO_STD 17'h00100
`define HCPP_SIZE_ZERO_EXT 17'h10000
`define HCPP_PUT_MAX_EXT 17'h00400
`define HCPP_ERR_OK 8'h00
`define HCPP_ERR_CKSUM 8'h01
`define HCPP_ERR_PASS 8'h02
`define HCPP_ERR_SIZE 8'h03
`endif

// [src/hcpp_skid.v]
// Two-entry buffer with registered outputs on the reply path
`timescale 1ns/1ns
module hcpp_skid #(
  parameter W = 8
) (
  input wire clk_in, // Clock
  input wire reset_in, // Async reset, active high
  input wire in_valid_in, // Word offered
  input wire [W-1:0] in_data_in, // Word
  output wire in_ready_out, // Room for a word
  output wire out_valid_out, // Word available
  output wire [W-1:0] out_data_out, // Word
  input wire out_ready_in // Receiver takes word
);
  reg out_valid_ff;
  reg [W-1:0] out_data_ff;
  reg spare_valid_ff;
  reg [W-1:0] spare_data_ff;
  reg in_ready_ff;
  wire push;
  wire pop;

  assign push = in_valid_in & in_ready_ff;
  assign pop = out_valid_ff & out_ready_in;
  assign in_ready_out = in_ready_ff;
  assign out_valid_out = out_valid_ff;
  assign out_data_out = out_data_ff;

  // Ready is registered, so the spare slot catches the word in flight
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      out_valid_ff <= 1'b0;
      out_data_ff <= {W{1'b0}};
      spare_valid_ff <= 1'b0;
      spare_data_ff <= {W{1'b0}};
      in_ready_ff <= 1'b0;
    end else begin
      if (spare_valid_ff) begin
        if (pop) begin
          out_data_ff <= spare_data_ff;
          spare_valid_ff <= 1'b0;
          in_ready_ff <= 1'b1;
        end
      end else if (push && (!out_valid_ff || pop)) begin
        out_data_ff <= in_data_in;
        out_valid_ff <= 1'b1;
        in_ready_ff <= 1'b1;
      end else if (push) begin
        spare_data_ff <= in_data_in;
        spare_valid_ff <= 1'b1;
        in_ready_ff <= 1'b0;
      end else begin
        if (pop) begin
          out_valid_ff <= 1'b0;
        end
        in_ready_ff <= 1'b1;
      end
    end
  end
endmodule // hcpp_skid

// [src/hcpp_parser.v]
// ASCII-hex command parser and reply generator for the logger host link
`timescale 1ns/1ns
`include "hcpp_consts.vh"
module hcpp_parser #(
  parameter [16:0] TBL_FULL_SIZE = 17'h00100,
  parameter [31:0] TBL_BASE = 32'h00000000
) (
  input wire clk_in, // Clock, 250 MHz
  input wire reset_in, // Async reset, active high
  input wire [7:0] rx_data_in, // Received character
  input wire rx_valid_in, // Character offered
  output reg rx_ready_out, // Parser takes character
  output wire [7:0] tx_data_out, // Reply character
  output wire tx_valid_out, // Reply character valid
  input wire tx_ready_in, // Host link takes reply character
  input wire [15:0] serial_num_in, // Unit serial number
  output reg [31:0] mem_addr_out, // Memory byte address
  output reg [7:0] mem_wdata_out, // Memory write byte
  output reg mem_we_out, // Memory write strobe
  output reg mem_re_out, // Memory read strobe
  input wire [7:0] mem_rdata_in, // Read byte, cycle after read strobe
  output reg tbl_sel_out, // Accesses go to configuration table
  output reg [7:0] param_out, // Test or initialise parameter
  output reg test_out, // Test command pulse
  output reg init_out, // Initialise command pulse
  output reg pwr_down_out // Power-down command pulse
);
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_PASS = 4'h1;
  localparam [3:0] S_ADDR = 4'h2;
  localparam [3:0] S_SIZE = 4'h3;
  localparam [3:0] S_PARAM = 4'h4;
  localparam [3:0] S_DATA = 4'h5;
  localparam [3:0] S_CKS = 4'h6;
  localparam [3:0] S_EXEC = 4'h7;
  localparam [3:0] S_RDREQ = 4'h8;
  localparam [3:0] S_RDWAIT = 4'h9;
  localparam [3:0] S_RDCAP = 4'ha;
  localparam [3:0] S_TXD = 4'hb;
  localparam [3:0] S_TXP = 4'hc;
  localparam [3:0] S_TXCR = 4'hd;

  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [7:0] cmd_ff;
  reg ext_ff;
  reg [3:0] nib_ff;
  reg [31:0] acc_ff;
  reg [15:0] csum_ff;
  reg [15:0] rcks_ff;
  reg pass_ok_ff;
  reg [31:0] addr_ff;
  reg [16:0] size_ff;
  reg [16:0] cnt_ff;
  reg wr_en_ff;
  reg [7:0] byte_ff;
  reg hi_ff;
  reg [15:0] pre_ff;
  reg [1:0] pre_cnt_ff;
  reg cks_en_ff;
  reg in_cks_ff;
  reg [15:0] rsum_ff;

  wire take;
  wire [4:0] hexv;
  wire [31:0] new_acc;
  wire [7:0] new_byte;
  wire [3:0] need;
  wire field_done;
  wire [7:0] letter;
  wire known;
  wire [16:0] size_val;
  wire sum_ok;
  wire push_valid;
  reg [7:0] push_data;
  wire push_ready;

  // Accepts both digit cases; bit 4 flags a hex digit
  function [4:0] hex2nib;
    input [7:0] c;
    begin
      if (c >= 8'h30 && c <= 8'h39) begin
        hex2nib = {1'b1, c[3:0]};
      end else if ((c >= 8'h41 && c <= 8'h46) ||
                   (c >= 8'h61 && c <= 8'h66)) begin
        hex2nib = {1'b1, c[3:0] + 4'h9};
      end else begin
        hex2nib = 5'h00;
      end
    end
  endfunction

  function [7:0] nib2hex;
    input [3:0] n;
    begin
      if (n < 4'ha) begin
        nib2hex = {4'h3, n};
      end else begin
        nib2hex = 8'h37 + {4'h0, n};
      end
    end
  endfunction

  function is_cmd;
    input [7:0] u;
    begin
      is_cmd = (u == `HCPP_CMD_GET) || (u == `HCPP_CMD_PUT) ||
               (u == `HCPP_CMD_WRP) || (u == `HCPP_CMD_RDP) ||
               (u == `HCPP_CMD_TST) || (u == `HCPP_CMD_INI) ||
               (u == `HCPP_CMD_TBL) || (u == `HCPP_CMD_NUM) ||
               (u == `HCPP_CMD_OFF);
    end
  endfunction

  assign take = rx_valid_in & rx_ready_out;
  assign hexv = hex2nib(rx_data_in);
  assign new_acc = {acc_ff[27:0], hexv[3:0]};
  assign new_byte = new_acc[7:0];
  assign letter = rx_data_in & 8'hdf;
  assign known = (rx_data_in[7:6] == 2'b01) & is_cmd(letter);

  assign need = (state_ff == S_PASS) ? `HCPP_NIBS_PASS :
                (state_ff == S_ADDR) ?
                  (ext_ff ? `HCPP_NIBS_ADDR_EXT : `HCPP_NIBS_ADDR_STD) :
                (state_ff == S_SIZE) ?
                  ((ext_ff && cmd_ff != `HCPP_CMD_TBL) ?
                    `HCPP_NIBS_SIZE_EXT : `HCPP_NIBS_SIZE_STD) :
                (state_ff == S_PARAM) ? `HCPP_NIBS_PARAM :
                (state_ff == S_CKS) ? `HCPP_NIBS_CKS : 4'h2;
  assign field_done = (nib_ff + 4'h1) == need;

  // Zero size means the full range
  assign size_val = (ext_ff && cmd_ff != `HCPP_CMD_TBL) ?
    ((new_acc[15:0] == 16'h0000) ? `HCPP_SIZE_ZERO_EXT :
      {1'b0, new_acc[15:0]}) :
    ((new_acc[7:0] == 8'h00) ? `HCPP_SIZE_ZERO_STD :
      {9'h000, new_acc[7:0]});

  // Only extended requests carry a checksum
  assign sum_ok = !ext_ff || (rcks_ff == csum_ff);

  assign push_valid = (state_ff == S_TXD) || (state_ff == S_TXCR) ||
                      (state_ff == S_TXP && pre_cnt_ff != 2'h0);

  // Each byte leaves as two hex characters, high first
  always @* begin
    push_data = `HCPP_CH_CR;
    if (state_ff == S_TXD) begin
      push_data = nib2hex(hi_ff ? byte_ff[7:4] : byte_ff[3:0]);
    end else if (state_ff == S_TXP) begin
      push_data = nib2hex(hi_ff ? pre_ff[15:12] : pre_ff[11:8]);
    end
  end

  hcpp_skid #(
    .W(8)
  ) u_skid (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .in_valid_in(push_valid),
    .in_data_in(push_data),
    .in_ready_out(push_ready),
    .out_valid_out(tx_valid_out),
    .out_data_out(tx_data_out),
    .out_ready_in(tx_ready_in)
  );

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        if (take && known) begin
          if (letter == `HCPP_CMD_WRP || letter == `HCPP_CMD_RDP ||
              letter == `HCPP_CMD_TST || letter == `HCPP_CMD_INI) begin
            nxt_state = S_PASS;
          end else if (letter == `HCPP_CMD_GET ||
                       letter == `HCPP_CMD_PUT) begin
            nxt_state = S_ADDR;
          end else if (letter == `HCPP_CMD_TBL &&
                       rx_data_in[`HCPP_CASE_BIT]) begin
            nxt_state = S_SIZE;
          end else begin
            nxt_state = S_EXEC;
          end
        end
      end
      S_PASS, S_ADDR, S_SIZE, S_PARAM, S_DATA, S_CKS: begin
        // A stray character drops the request silently
        if (take && !hexv[4]) begin
          nxt_state = S_IDLE;
        end else if (take && field_done) begin
          case (state_ff)
            S_PASS: begin
              nxt_state = (cmd_ff == `HCPP_CMD_TST ||
                cmd_ff == `HCPP_CMD_INI) ? S_PARAM : S_ADDR;
            end
            S_ADDR: begin
              nxt_state = S_SIZE;
            end
            S_SIZE: begin
              if (cmd_ff == `HCPP_CMD_PUT || cmd_ff == `HCPP_CMD_WRP) begin
                nxt_state = S_DATA;
              end else if (ext_ff && cmd_ff != `HCPP_CMD_TBL) begin
                nxt_state = S_CKS;
              end else begin
                nxt_state = S_EXEC;
              end
            end
            S_DATA: begin
              if (cnt_ff == 17'h00001) begin
                nxt_state = ext_ff ? S_CKS : S_EXEC;
              end
            end
            default: begin
              nxt_state = S_EXEC;
            end
          endcase
        end
      end
      S_EXEC: begin
        nxt_state = S_IDLE;
        case (cmd_ff)
          // Bad checksum on get or read: silence
          `HCPP_CMD_GET: begin
            if (sum_ok) begin
              nxt_state = S_RDREQ;
            end
          end
          `HCPP_CMD_RDP: begin
            if (sum_ok && (pass_ok_ff || ext_ff)) begin
              nxt_state = S_RDREQ;
            end
          end
          `HCPP_CMD_PUT, `HCPP_CMD_WRP, `HCPP_CMD_INI: begin
            if (ext_ff || cmd_ff == `HCPP_CMD_INI) begin
              nxt_state = S_RDREQ;
            end
          end
          `HCPP_CMD_TBL, `HCPP_CMD_NUM: begin
            nxt_state = S_RDREQ;
          end
          default: begin
            nxt_state = S_IDLE;
          end
        endcase
      end
      S_RDREQ: begin
        nxt_state = (cnt_ff == 17'h00000) ? S_TXP : S_RDWAIT;
      end
      S_RDWAIT: begin
        nxt_state = S_RDCAP;
      end
      S_RDCAP: begin
        nxt_state = S_TXD;
      end
      S_TXD: begin
        if (push_ready && !hi_ff) begin
          nxt_state = S_RDREQ;
        end
      end
      S_TXP: begin
        if (pre_cnt_ff == 2'h0 && !(cks_en_ff && !in_cks_ff)) begin
          nxt_state = S_TXCR;
        end
      end
      S_TXCR: begin
        if (push_ready) begin
          nxt_state = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_ff <= S_IDLE;
      cmd_ff <= 8'h00;
      ext_ff <= 1'b0;
      nib_ff <= 4'h0;
      acc_ff <= 32'h00000000;
      csum_ff <= 16'h0000;
      rcks_ff <= 16'h0000;
      pass_ok_ff <= 1'b0;
      addr_ff <= 32'h00000000;
      size_ff <= 17'h00000;
      cnt_ff <= 17'h00000;
      wr_en_ff <= 1'b0;
      byte_ff <= 8'h00;
      hi_ff <= 1'b1;
      pre_ff <= 16'h0000;
      pre_cnt_ff <= 2'h0;
      cks_en_ff <= 1'b0;
      in_cks_ff <= 1'b0;
      rsum_ff <= 16'h0000;
      rx_ready_out <= 1'b0;
      mem_addr_out <= 32'h00000000;
      mem_wdata_out <= 8'h00;
      mem_we_out <= 1'b0;
      mem_re_out <= 1'b0;
      tbl_sel_out <= 1'b0;
      param_out <= 8'h00;
      test_out <= 1'b0;
      init_out <= 1'b0;
      pwr_down_out <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      rx_ready_out <= (nxt_state <= S_CKS);
      mem_we_out <= 1'b0;
      mem_re_out <= 1'b0;
      test_out <= 1'b0;
      init_out <= 1'b0;
      pwr_down_out <= 1'b0;
      if (state_ff == S_IDLE) begin
        if (take && known) begin
          cmd_ff <= letter;
          ext_ff <= rx_data_in[`HCPP_CASE_BIT];
          nib_ff <= 4'h0;
          csum_ff <= 16'h0000;
          acc_ff <= 32'h00000000;
          pass_ok_ff <= 1'b0;
          tbl_sel_out <= (letter == `HCPP_CMD_TBL);
          size_ff <= TBL_FULL_SIZE;
          addr_ff <= TBL_BASE;
        end
      end else if (state_ff <= S_CKS && take && hexv[4]) begin
        acc_ff <= new_acc;
        nib_ff <= field_done ? 4'h0 : nib_ff + 4'h1;
        // Sum binary bytes, checksum field left out
        if (nib_ff[0] && state_ff != S_CKS) begin
          csum_ff <= csum_ff + {8'h00, new_byte};
        end
        if (field_done) begin
          case (state_ff)
            S_PASS: begin
              pass_ok_ff <= ({new_acc[7:0], new_acc[15:8]} ==
                serial_num_in);
            end
            S_ADDR: begin
              addr_ff <= ext_ff ? new_acc : {16'h0000, new_acc[15:0]};
            end
            S_SIZE: begin
              size_ff <= size_val;
              cnt_ff <= size_val;
              wr_en_ff <= !(cmd_ff == `HCPP_CMD_WRP && !pass_ok_ff) &&
                !(ext_ff && size_val > `HCPP_PUT_MAX_EXT);
            end
            S_PARAM: begin
              param_out <= new_byte;
            end
            S_DATA: begin
              // Store each byte as it completes, when wr_en_ff allows writes
              mem_we_out <= wr_en_ff;
              mem_addr_out <= addr_ff;
              mem_wdata_out <= new_byte;
              addr_ff <= addr_ff + 32'h00000001;
              cnt_ff <= cnt_ff - 17'h00001;
            end
            default: begin
              rcks_ff <= new_acc[15:0];
            end
          endcase
        end
      end
      if (state_ff == S_EXEC) begin
        rsum_ff <= 16'h0000;
        hi_ff <= 1'b1;
        in_cks_ff <= 1'b0;
        cks_en_ff <= 1'b1;
        pre_cnt_ff <= 2'h0;
        cnt_ff <= 17'h00000;
        case (cmd_ff)
          `HCPP_CMD_GET, `HCPP_CMD_TBL: begin
            cnt_ff <= size_ff;
            pre_ff <= {`HCPP_ERR_OK, 8'h00};
            pre_cnt_ff <= ext_ff && cmd_ff == `HCPP_CMD_GET ? 2'h1 : 2'h0;
          end
          `HCPP_CMD_RDP: begin
            cnt_ff <= pass_ok_ff ? size_ff : 17'h00000;
            pre_ff <= {pass_ok_ff ? `HCPP_ERR_OK : `HCPP_ERR_PASS, 8'h00};
            pre_cnt_ff <= ext_ff ? 2'h1 : 2'h0;
          end
          `HCPP_CMD_PUT, `HCPP_CMD_WRP: begin
            pre_cnt_ff <= 2'h1;
            if (!sum_ok) begin
              pre_ff <= {`HCPP_ERR_CKSUM, 8'h00};
            end else if (cmd_ff == `HCPP_CMD_WRP && !pass_ok_ff) begin
              pre_ff <= {`HCPP_ERR_PASS, 8'h00};
            end else if (size_ff > `HCPP_PUT_MAX_EXT) begin
              pre_ff <= {`HCPP_ERR_SIZE, 8'h00};
            end else begin
              pre_ff <= {`HCPP_ERR_OK, 8'h00};
            end
          end
          `HCPP_CMD_INI: begin
            // Parameter acts only with a matching password
            init_out <= pass_ok_ff;
            pre_ff <= {pass_ok_ff ? `HCPP_ERR_OK : `HCPP_ERR_PASS, 8'h00};
            pre_cnt_ff <= 2'h1;
            cks_en_ff <= 1'b0;
          end
          `HCPP_CMD_TST: begin
            test_out <= pass_ok_ff;
          end
          `HCPP_CMD_NUM: begin
            pre_ff <= {serial_num_in[7:0], serial_num_in[15:8]};
            pre_cnt_ff <= 2'h2;
          end
          default: begin
            pwr_down_out <= (cmd_ff == `HCPP_CMD_OFF);
          end
        endcase
      end
      if (state_ff == S_RDREQ && cnt_ff != 17'h00000) begin
        mem_re_out <= 1'b1;
        mem_addr_out <= addr_ff;
      end
      if (state_ff == S_RDCAP) begin
        byte_ff <= mem_rdata_in;
        rsum_ff <= rsum_ff + {8'h00, mem_rdata_in};
        hi_ff <= 1'b1;
      end
      if (state_ff == S_TXD && push_ready) begin
        hi_ff <= !hi_ff;
        if (!hi_ff) begin
          cnt_ff <= cnt_ff - 17'h00001;
          addr_ff <= addr_ff + 32'h00000001;
        end
      end
      if (state_ff == S_TXP) begin
        if (pre_cnt_ff == 2'h0) begin
          // Checksum covers everything sent before it
          if (cks_en_ff && !in_cks_ff) begin
            pre_ff <= rsum_ff;
            pre_cnt_ff <= 2'h2;
            in_cks_ff <= 1'b1;
            hi_ff <= 1'b1;
          end
        end else if (push_ready) begin
          hi_ff <= !hi_ff;
          if (!hi_ff) begin
            pre_ff <= {pre_ff[7:0], 8'h00};
            pre_cnt_ff <= pre_cnt_ff - 2'h1;
            if (!in_cks_ff) begin
              rsum_ff <= rsum_ff + {8'h00, pre_ff[15:8]};
            end
          end
        end
      end
    end
  end
endmodule // hcpp_parser

// [bench/hcpp_parser_monitor.sv]
// Concurrent checks on the parser link and strobe ports
`timescale 1ns/1ns
`include "hcpp_consts.vh"
module hcpp_monitor (
  input wire clk_in, // Clock
  input wire reset_in, // Async reset
  input wire [7:0] rx_data_in, // Request char
  input wire rx_valid_in, // Request valid
  input wire rx_ready_out, // Request taken
  input wire [7:0] tx_data_out, // Reply char
  input wire tx_valid_out, // Reply valid
  input wire tx_ready_in, // Reply taken
  input wire mem_we_out, // Write strobe
  input wire mem_re_out, // Read strobe
  input wire test_out, // Test pulse
  input wire init_out, // Init pulse
  input wire pwr_down_out // Power-down pulse
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire take = rx_valid_in && rx_ready_out;
  hex_upper_a: assert property (tx_valid_out |->
    tx_data_out == `HCPP_CH_CR || tx_data_out inside {[8'h30:8'h39]}
    || tx_data_out inside {[8'h41:8'h46]}) else $error("bad reply char");
  tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=>
    tx_valid_out && $stable(tx_data_out)) else $error("reply char lost");
  we_pulse_a: assert property (mem_we_out |=> !mem_we_out)
    else $error("write strobe too long");
  re_gap_a: assert property (mem_re_out |=> !mem_re_out [*3])
    else $error("read strobes too close");
  strobe_one_a: assert property (
    $onehot0({mem_we_out, mem_re_out, test_out, init_out, pwr_down_out}))
    else $error("strobes overlap");
  // Closing CR may appear as ready returns, so it is left out
  reply_busy_a: assert property ($rose(tx_valid_out) &&
    tx_data_out != `HCPP_CH_CR |-> !rx_ready_out)
    else $error("reply while collecting");
  num_exec_a: assert property (
    take && rx_data_in == `HCPP_CMD_NUM |=> !rx_ready_out)
    else $error("number command not executed");
  kill_pulse_a: assert property (
    take && rx_data_in == `HCPP_CMD_OFF |-> ##[1:16] pwr_down_out)
    else $error("no power-down pulse");
  test_pulse_a: assert property (test_out |=> !test_out)
    else $error("test pulse too long");
  cover property (mem_we_out);
  cover property (mem_re_out);
  cover property (tx_valid_out && !tx_ready_in);
  cover property (pwr_down_out);
endmodule // hcpp_monitor
bind hcpp_parser hcpp_monitor hcpp_monitor_inst (.clk_in, .reset_in,
  .rx_data_in, .rx_valid_in, .rx_ready_out, .tx_data_out, .tx_valid_out,
  .tx_ready_in, .mem_we_out, .mem_re_out, .test_out, .init_out,
  .pwr_down_out);

// [bench/hcpp_host.sv]
// Host computer model: sends requests, takes replies with stalls
`timescale 1ns/1ns
module hcpp_host (
  input wire clk_in, // Clock
  output reg [7:0] rx_data_out, // Request char
  output reg rx_valid_out, // Request valid
  input wire rx_ready_in, // Parser takes char
  input wire [7:0] tx_data_in, // Reply char
  input wire tx_valid_in, // Reply valid
  output reg tx_ready_out // Host takes reply
);
  reg [7:0] got_q[$];
  reg stall_all = 1'b0;
  initial begin
    rx_data_out = 8'hff;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
  end
  // Random stalls keep the reply buffer busy
  always @(posedge clk_in) begin
    if (tx_valid_in && tx_ready_out) got_q.push_back(tx_data_in);
    tx_ready_out <= #1 !stall_all && ($urandom % 4 != 0);
  end
  // Valid held through back-to-back chars
  task send(input [7:0] c, output reg ok);
    integer n;
    begin
      rx_data_out = c;
      rx_valid_out = 1'b1;
      n = 0;
      @(posedge clk_in);
      while (rx_ready_in !== 1'b1 && n < 500) begin
        n = n + 1;
        @(posedge clk_in);
      end
      ok = (n < 500);
      #1;
    end
  endtask
  // Released line shows no stale value
  task idle;
    begin
      rx_valid_out = 1'b0;
      rx_data_out = ~rx_data_out;
    end
  endtask
endmodule // hcpp_host

// [bench/hex_command_protocol_parser_tb.sv]
// Self-checking bench for the hex command parser
`timescale 1ns/1ns
`include "hcpp_consts.vh"
module hex_command_protocol_parser_tb;
  reg clk_in = 1'b0;
  reg reset_in = 1'b1;
  reg [15:0] ser = 16'h0000;
  reg [7:0] mem_rdata_in = 8'h00;
  wire [7:0] rx_d, tx_d, wdat, param;
  wire rx_v, rx_r, tx_v, tx_r, we, re, tsel, tst, ini, pwr;
  wire [31:0] addr;
  integer bad_count = 0;
  integer checked = 0;
  integer tst_n = 0;
  integer ini_n = 0;
  integer pwr_n = 0;
  integer i, k, n;
  reg [39:0] wq[$];
  reg [7:0] exp_q[$];
  reg [7:0] d[0:255];
  reg [15:0] sum, c, p;
  reg [31:0] a;
  initial forever #2 clk_in = ~clk_in;
  hcpp_parser hcpp_parser_inst (.clk_in(clk_in), .reset_in(reset_in),
    .rx_data_in(rx_d), .rx_valid_in(rx_v), .rx_ready_out(rx_r),
    .tx_data_out(tx_d), .tx_valid_out(tx_v), .tx_ready_in(tx_r),
    .serial_num_in(ser), .mem_addr_out(addr), .mem_wdata_out(wdat),
    .mem_we_out(we), .mem_re_out(re), .mem_rdata_in(mem_rdata_in),
    .tbl_sel_out(tsel), .param_out(param), .test_out(tst),
    .init_out(ini), .pwr_down_out(pwr));
  hcpp_host hcpp_host_inst (.clk_in(clk_in), .rx_data_out(rx_d),
    .rx_valid_out(rx_v), .rx_ready_in(rx_r), .tx_data_in(tx_d),
    .tx_valid_in(tx_v), .tx_ready_out(tx_r));
  function [7:0] mbyte(input [31:0] x);
    mbyte = x[7:0] ^ x[15:8] ^ 8'h3c;
  endfunction
  function [7:0] hx(input [3:0] v);
    hx = (v < 4'ha) ? 8'h30 + v : 8'h37 + v;
  endfunction
  // Memory answers the cycle after the strobe, noise otherwise
  always @(posedge clk_in) begin
    if (we === 1'b1) wq.push_back({addr, wdat});
    if (tst === 1'b1) tst_n = tst_n + 1;
    if (ini === 1'b1) ini_n = ini_n + 1;
    if (pwr === 1'b1) pwr_n = pwr_n + 1;
    mem_rdata_in <= #1 (re === 1'b1) ? mbyte(addr) : $urandom;
  end
  task results;
    begin
      if (bad_count == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk_val(input [39:0] g, input [39:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task tx1(input [7:0] ch);
    reg ok;
    begin
      hcpp_host_inst.send(ch, ok);
      if (!ok) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0t request not taken", $time);
        results;
      end
    end
  endtask
  task sh(input [31:0] v, input integer m);
    integer j;
    for (j = m - 1; j >= 0; j = j - 1) tx1(hx(v[j*4 +: 4]));
  endtask
  task eb(input [7:0] b);
    begin
      exp_q.push_back(hx(b[7:4]));
      exp_q.push_back(hx(b[3:0]));
      sum = sum + b;
    end
  endtask
  task ecks;
    reg [15:0] s;
    begin
      s = sum;
      eb(s[15:8]);
      eb(s[7:0]);
      exp_q.push_back(`HCPP_CH_CR);
    end
  endtask
  task chk_reply;
    integer j;
    begin
      hcpp_host_inst.idle;
      j = 0;
      while (hcpp_host_inst.got_q.size() < exp_q.size() && j < 4000) begin
        j = j + 1;
        @(posedge clk_in);
      end
      repeat (60) @(posedge clk_in);
      #1;
      chk_val(hcpp_host_inst.got_q.size(), exp_q.size());
      if (hcpp_host_inst.got_q.size() == exp_q.size())
        foreach (exp_q[m]) chk_val(hcpp_host_inst.got_q[m], exp_q[m]);
      if (j == 4000) results;
      hcpp_host_inst.got_q.delete();
      exp_q.delete();
      sum = 16'h0000;
    end
  endtask
  initial begin
    void'($urandom(32'h236f));
    ser = $urandom;
    sum = 16'h0000;
    repeat (6) @(posedge clk_in);
    #1 reset_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    tx1(`HCPP_CMD_NUM);
    eb(ser[7:0]);
    eb(ser[15:8]);
    ecks;
    chk_reply;
    for (k = 0; k < 2; k = k + 1) begin
      a = $urandom;
      n = k ? 256 : 2;
      tx1(`HCPP_CMD_PUT);
      sh(a, 4);
      sh(n, 2);
      for (i = 0; i < n; i = i + 1) begin
        d[i] = $urandom;
        sh(d[i], 2);
      end
      chk_reply;
      chk_val(wq.size(), n);
      foreach (wq[m]) chk_val(wq[m], {{16'h0, a[15:0]} + m, d[m]});
      wq.delete();
    end
    a = $urandom;
    tx1(`HCPP_CMD_GET);
    sh(a, 4);
    sh(8, 2);
    hcpp_host_inst.stall_all = 1'b1;
    repeat (80) @(posedge clk_in);
    #1 hcpp_host_inst.stall_all = 1'b0;
    for (i = 0; i < 8; i = i + 1) eb(mbyte({16'h0, a[15:0]} + i));
    ecks;
    chk_reply;
    for (k = 0; k < 2; k = k + 1) begin
      a = $urandom;
      c = 16'h0002 + a[31:24] + a[23:16] + a[15:8] + a[7:0];
      tx1(`HCPP_CMD_GET | 8'h20);
      sh(a, 8);
      sh(2, 4);
      sh(c + k, 4);
      if (k == 0) begin
        for (i = 0; i < 2; i = i + 1) eb(mbyte(a + i));
        eb(`HCPP_ERR_OK);
        ecks;
      end
      chk_reply;
    end
    for (k = 0; k < 2; k = k + 1) begin
      a = $urandom;
      d[0] = $urandom;
      p = ser ^ k;
      tx1(`HCPP_CMD_WRP);
      sh({p[7:0], p[15:8]}, 4);
      sh(a, 4);
      sh(1, 2);
      sh(d[0], 2);
      chk_reply;
      chk_val(wq.size(), 1 - k);
      if (k == 0) chk_val(wq[0], {{16'h0, a[15:0]}, d[0]});
      wq.delete();
    end
    for (k = 0; k < 2; k = k + 1) begin
      a = $urandom;
      n = k ? 1025 : 2;
      c = n[15:8] + n[7:0] + a[31:24] + a[23:16] + a[15:8] + a[7:0];
      tx1(`HCPP_CMD_PUT | 8'h20);
      sh(a, 8);
      sh(n, 4);
      for (i = 0; i < n; i = i + 1) begin
        d[0] = $urandom;
        c = c + d[0];
        sh(d[0], 2);
      end
      sh(c, 4);
      eb(k ? `HCPP_ERR_SIZE : `HCPP_ERR_OK);
      ecks;
      chk_reply;
      chk_val(wq.size(), k ? 0 : n);
      wq.delete();
    end
    a = $urandom;
    tx1(`HCPP_CMD_RDP);
    sh({ser[7:0], ser[15:8]}, 4);
    sh(a, 4);
    sh(3, 2);
    for (i = 0; i < 3; i = i + 1) eb(mbyte({16'h0, a[15:0]} + i));
    ecks;
    chk_reply;
    tx1(`HCPP_CMD_TBL | 8'h20);
    sh(4, 2);
    for (i = 0; i < 4; i = i + 1) eb(mbyte(hcpp_parser_inst.TBL_BASE + i));
    ecks;
    chk_reply;
    chk_val(tsel, 1);
    for (k = 0; k < 2; k = k + 1) begin
      d[0] = $urandom;
      tx1(k ? `HCPP_CMD_INI : `HCPP_CMD_TST);
      sh({ser[7:0], ser[15:8]}, 4);
      sh(d[0], 2);
      if (k) begin
        eb(`HCPP_ERR_OK);
        exp_q.push_back(`HCPP_CH_CR);
      end
      chk_reply;
      chk_val(param, d[0]);
    end
    tx1(`HCPP_CMD_OFF);
    chk_reply;
    chk_val(tst_n + 2 * ini_n + 4 * pwr_n, 7);
    results;
  end
endmodule // hex_command_protocol_parser_tb
